// file: common/cpa_pkg.sv
// Shared constants, register map and carrier types of the power accumulator
// Assumes a 100 MHz core clock and an APB master with 32-bit data
//
// Overview of operation
// (RULE_01) Compute only after shunt and bus samples
// (RULE_02) Power uses latest bus and previous current
// (RULE_03) Zero calibration forces power to zero
// (RULE_04) Averaging above one keeps results intermediate
// (RULE_05) Add every new result into accumulator
// (RULE_06) Publish averaged current and power together
// (RULE_07) Arithmetic runs beside conversions, no delay
// (RULE_08) One shared converter, inputs in sequence
// (RULE_09) Continuous and triggered modes, host selected
// (RULE_10) One averaging count for all inputs
// (RULE_11) Ready flag after all conversions and averaging
// (RULE_12) Clear accumulator at each sequence start
package cpa_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] CPA_CTRL_OFF = 8'h00;
	localparam logic [7:0] CPA_CAL_OFF = 8'h04;
	localparam logic [7:0] CPA_CUR_OFF = 8'h08;
	localparam logic [7:0] CPA_PWR_OFF = 8'h0C;
	localparam logic [7:0] CPA_STAT_OFF = 8'h10;
	localparam logic [7:0] CPA_MASK_OFF = 8'h14;
	localparam logic [7:0] CPA_SMP_OFF = 8'h18;
	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CPA_MODE_LSB = 0;
	localparam int CPA_MODE_MSB = 1;
	localparam int CPA_AVG_LSB = 4;
	localparam int CPA_AVG_MSB = 6;
	localparam int CPA_CT_LSB = 8;
	localparam int CPA_CT_MSB = 10;
	localparam int CPA_TEMP_BIT = 12;
	// Status bits
	localparam int CPA_ST_READY = 0;
	localparam int CPA_ST_OVF = 1;
	localparam logic [31:0] CPA_ZERO = 32'h0000_0000;
	localparam logic [15:0] CPA_ZERO16 = 16'h0000;
	// Slave error answer code for unmapped addresses
	localparam logic CPA_ERR = 1'b1;
	// ----------------------------------------------------------------
	// Timing: converter sample period, one count of the 1 MHz tick
	// ----------------------------------------------------------------
	localparam int CPA_CLK_MHZ = 100;
	localparam int CPA_OSC_MHZ = 1;
	localparam int CPA_TICK_DIV = CPA_CLK_MHZ / CPA_OSC_MHZ;
	// Conversion times in microseconds, indexed by the time field
	localparam int CPA_CT_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
	// Averaging counts indexed by the averaging field
	localparam int CPA_AVG_N [8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CPA_MODE_OFF = 2'b00,
		CPA_MODE_TRIG = 2'b01,
		CPA_MODE_CONT = 2'b10,
		CPA_MODE_RSV = 2'b11
	} cpa_mode_t;
	typedef enum logic [1:0] {
		CPA_CH_SHUNT = 2'b00,
		CPA_CH_BUS = 2'b01,
		CPA_CH_TEMP = 2'b10
	} cpa_chan_t;
	// Sample from the shared converter
	typedef struct packed {
		logic valid;
		cpa_chan_t chan;
		logic [15:0] data;
	} cpa_sample_t;
	// Published result pair
	typedef struct packed {
		logic [31:0] current;
		logic [31:0] power;
	} cpa_result_t;
endpackage : cpa_pkg

// file: src/cpa_core.sv
// Current and power engine with sequencer and APB register file
// Averages reach the result registers only at the last bus sample of a sequence
// Assumes an external converter that samples the selected channel
// Assumes that converter returns one sample for each start pulse
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module cpa_core #(
	parameter int SMP_W = 16,
	parameter int ACC_W = 48
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Shared converter
	output cpa_pkg::cpa_chan_t conv_chan,
	output logic conv_start,
	input wire cpa_pkg::cpa_sample_t conv_sample,
	// Interrupt and ready
	output logic irq,
	output logic conversion_ready_flag
);
	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	// Shunt, bus and temperature each own one conversion slot; done
	// lasts a single cycle and raises the ready event
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SHUNT = 3'b001,
		S_BUS = 3'b010,
		S_TEMP = 3'b011,
		S_DONE = 3'b100
	} cpa_state_t;

	// Signed multiply of 16-bit by 16-bit, truncated to 32 bits
	function automatic logic [31:0] smul(input logic [15:0] a,
			input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		return p;
	endfunction : smul

	// Shift that divides a sum by its power-of-two sample count
	function automatic logic [3:0] log2_cnt(input logic [10:0] n);
		logic [3:0] r;
		r = 4'd0;
		// Highest set bit wins; counts are always powers of two
		for (int k = 0; k < $bits(n); k++) begin
			if (n[k]) begin
				r = 4'(k);
			end
		end
		return r;
	endfunction : log2_cnt

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] ctrl_reg;          // Mode, averaging, conv time
	logic [15:0] cal_reg;           // Shunt calibration
	cpa_pkg::cpa_result_t out_reg;  // Published results
	logic [1:0] stat_reg;           // Sticky events
	logic [1:0] mask_reg;           // Interrupt enables
	logic [15:0] bus_reg;           // Latest bus sample
	logic [15:0] temp_reg;          // Latest temperature sample
	logic [31:0] cur_reg;           // Last computed current
	// Accumulators are wide enough for 1024 full-scale 32-bit terms
	logic signed [ACC_W-1:0] acc_cur_reg;  // Current accumulator
	logic signed [ACC_W-1:0] acc_pwr_reg;  // Power accumulator
	logic [10:0] cnt_reg;           // Samples taken in sequence
	logic [6:0] tick_cnt_reg;       // 1 MHz divider
	logic [12:0] ct_cnt_reg;        // Conversion time counter
	logic busy_reg;                 // Conversion outstanding
	logic shunt_seen_reg;           // Shunt converted this round
	// Sequencer position and its next value
	cpa_state_t state_reg, state_next;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Zero wait states: every access completes in its first access cycle
	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite;
	wire logic rd = acc && !pwrite;
	wire logic hit_ctrl = paddr == cpa_pkg::CPA_CTRL_OFF;
	wire logic hit_cal = paddr == cpa_pkg::CPA_CAL_OFF;
	wire logic hit_cur = paddr == cpa_pkg::CPA_CUR_OFF;
	wire logic hit_pwr = paddr == cpa_pkg::CPA_PWR_OFF;
	wire logic hit_stat = paddr == cpa_pkg::CPA_STAT_OFF;
	wire logic hit_mask = paddr == cpa_pkg::CPA_MASK_OFF;
	wire logic hit_smp = paddr == cpa_pkg::CPA_SMP_OFF;
	wire logic mapped = hit_ctrl | hit_cal | hit_cur | hit_pwr | hit_stat
		| hit_mask | hit_smp;
	wire logic ctrl_wr = wr && hit_ctrl;

	// Control fields
	// Mode, averaging and timing all come straight from the control word
	wire cpa_pkg::cpa_mode_t mode =
		cpa_pkg::cpa_mode_t'(ctrl_reg[cpa_pkg::CPA_MODE_MSB:
		cpa_pkg::CPA_MODE_LSB]);
	wire logic [2:0] avg_sel =
		ctrl_reg[cpa_pkg::CPA_AVG_MSB:cpa_pkg::CPA_AVG_LSB];
	wire logic [2:0] ct_sel =
		ctrl_reg[cpa_pkg::CPA_CT_MSB:cpa_pkg::CPA_CT_LSB];
	wire logic temp_en = ctrl_reg[cpa_pkg::CPA_TEMP_BIT];
	wire cpa_pkg::cpa_mode_t new_mode =
		cpa_pkg::cpa_mode_t'(pwdata[cpa_pkg::CPA_MODE_MSB:
		cpa_pkg::CPA_MODE_LSB]);
	// Same averaging count applies to every channel  see (RULE_10)
	wire logic [10:0] avg_n = 11'(cpa_pkg::CPA_AVG_N[avg_sel]);
	wire logic [12:0] ct_us = 13'(cpa_pkg::CPA_CT_US[ct_sel]);
	wire logic tick = tick_cnt_reg == 7'(cpa_pkg::CPA_TICK_DIV - 1);
	wire logic conv_due = !busy_reg && ct_cnt_reg == ct_us;

	// Current and power arithmetic, combinational beside sampling
	// A sample counts only while a conversion is outstanding; anything
	// else is treated as stray and only flagged in status
	wire logic smp_ok = conv_sample.valid && busy_reg;
	wire logic shunt_in = smp_ok && conv_sample.chan == cpa_pkg::CPA_CH_SHUNT;
	wire logic bus_in = smp_ok && conv_sample.chan == cpa_pkg::CPA_CH_BUS;
	wire logic temp_in = smp_ok && conv_sample.chan == cpa_pkg::CPA_CH_TEMP;
	wire logic [31:0] cur_new = smul(conv_sample.data, cal_reg);
	// Power from newest bus sample and previous current  see (RULE_02)
	wire logic [31:0] pwr_new = (cal_reg == cpa_pkg::CPA_ZERO16) ?
		cpa_pkg::CPA_ZERO :                              // see (RULE_03)
		smul(conv_sample.data, cur_reg[31:16]);
	// Both samples present before results form  see (RULE_01)
	wire logic calc = bus_in && shunt_seen_reg;
	// With a count of one every pass is the last and publishes at once
	wire logic last = calc && (cnt_reg + 11'd1 == avg_n);
	wire logic seq_end = state_reg == S_DONE;
	// Current term is the one latched at the shunt sample; the bus
	// sample on this cycle only feeds the power product
	wire logic [ACC_W-1:0] cur_sum = acc_cur_reg + ACC_W'($signed(cur_reg));
	wire logic [ACC_W-1:0] pwr_sum = acc_pwr_reg + ACC_W'($signed(pwr_new));
	// Divide by the sample count; a count of one shifts by zero
	wire logic [3:0] sh = log2_cnt(avg_n);

	// ----------------------------------------------------------------
	// Sequencer: one channel at a time on the converter  see (RULE_08)
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE: begin
				if (mode == cpa_pkg::CPA_MODE_TRIG ||
						mode == cpa_pkg::CPA_MODE_CONT) begin
					state_next = S_SHUNT;
				end
			end
			S_SHUNT: begin
				if (shunt_in) begin
					state_next = S_BUS;
				end
			end
			S_BUS: begin
				if (bus_in) begin
					state_next = temp_en ? S_TEMP :
						(last ? S_DONE : S_SHUNT);
				end
			end
			S_TEMP: begin
				if (temp_in) begin
					state_next = (cnt_reg == avg_n) ? S_DONE : S_SHUNT;
				end
			end
			S_DONE: begin
				// Continuous loops, triggered stops  see (RULE_09)
				state_next = S_IDLE;
			end
			default: begin
				state_next = S_IDLE;
			end
		endcase
		// A control write aborts the pass; idle then restarts it cleanly
		if (ctrl_wr) begin
			state_next = S_IDLE;
		end
	end

	// Converter channel follows state
	// Only one input reaches the converter at a time
	assign conv_chan = (state_reg == S_BUS) ? cpa_pkg::CPA_CH_BUS :
		(state_reg == S_TEMP) ? cpa_pkg::CPA_CH_TEMP : cpa_pkg::CPA_CH_SHUNT;
	wire logic conv_state = state_reg == S_SHUNT || state_reg == S_BUS ||
		state_reg == S_TEMP;
	assign conv_start = conv_state && conv_due && tick;

	// State and conversion timing
	// The divider makes the oscillator tick as a one-cycle enable; the
	// wait counter counts whole ticks before each start, and busy keeps
	// a second start away until the converter has answered
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= S_IDLE;
			tick_cnt_reg <= 7'd0;
			ct_cnt_reg <= 13'd0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			tick_cnt_reg <= tick ? 7'd0 : tick_cnt_reg + 7'd1;
			if (!conv_state || ctrl_wr || conv_start) begin
				ct_cnt_reg <= 13'd0;
			end else if (tick && !conv_due && !busy_reg) begin
				ct_cnt_reg <= ct_cnt_reg + 13'd1;
			end
			busy_reg <= ctrl_wr ? 1'b0 : (conv_start ? 1'b1 :
				(smp_ok ? 1'b0 : busy_reg));
		end
	end

	// ----------------------------------------------------------------
	// Accumulation, runs without holding the sequencer  see (RULE_07)
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			shunt_seen_reg <= 1'b0;
			cur_reg <= cpa_pkg::CPA_ZERO;
			bus_reg <= cpa_pkg::CPA_ZERO16;
			temp_reg <= cpa_pkg::CPA_ZERO16;
			acc_cur_reg <= '0;
			acc_pwr_reg <= '0;
			cnt_reg <= 11'd0;
		end else if (ctrl_wr || seq_end) begin
			// Clear has priority, so a write mid-average drops partial sums
			// Fresh sequence starts empty  see (RULE_12)
			acc_cur_reg <= '0;
			acc_pwr_reg <= '0;
			cnt_reg <= 11'd0;
			shunt_seen_reg <= 1'b0;
		end else begin
			if (shunt_in) begin
				shunt_seen_reg <= 1'b1;
				cur_reg <= cur_new;
			end
			if (bus_in) begin
				bus_reg <= conv_sample.data;
			end
			if (temp_in) begin
				temp_reg <= conv_sample.data;
			end
			if (calc) begin
				// Intermediate sums, not published  see (RULE_04)
				acc_cur_reg <= $signed(cur_sum);  // see (RULE_05)
				acc_pwr_reg <= $signed(pwr_sum);
				cnt_reg <= cnt_reg + 11'd1;
				shunt_seen_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Publish averaged pair in one update  see (RULE_06)
	// ----------------------------------------------------------------
	// Arithmetic shift keeps a negative average negative
	wire logic [ACC_W-1:0] cur_avg = $signed(cur_sum) >>> sh;
	wire logic [ACC_W-1:0] pwr_avg = $signed(pwr_sum) >>> sh;
	// Result registers load once per sequence, never mid-average
	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_reg <= '0;
		end else if (last && !ctrl_wr) begin
			// A restarting write discards the final sample too
			out_reg.current <= cur_avg[31:0];
			out_reg.power <= pwr_avg[31:0];
		end
	end

	// ----------------------------------------------------------------
	// Control and status registers
	// ----------------------------------------------------------------
	wire logic ready_evt = seq_end;
	wire logic stat_clr_rd = rd && hit_stat;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_reg <= cpa_pkg::CPA_ZERO;
			cal_reg <= cpa_pkg::CPA_ZERO16;
			mask_reg <= 2'b00;
			stat_reg <= 2'b00;
			conversion_ready_flag <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				ctrl_reg <= pwdata;
			end
			if (wr && hit_cal) begin
				cal_reg <= pwdata[15:0];
			end
			if (wr && hit_mask) begin
				mask_reg <= pwdata[1:0];
			end
			// Bit one marks a stray sample, one with no start outstanding
			// Sticky events; set beats write-one clear
			stat_reg[cpa_pkg::CPA_ST_READY] <= ready_evt ||
				(stat_reg[cpa_pkg::CPA_ST_READY] &&
				!(wr && hit_stat && pwdata[cpa_pkg::CPA_ST_READY]));
			stat_reg[cpa_pkg::CPA_ST_OVF] <= (conv_sample.valid && !busy_reg) ||
				(stat_reg[cpa_pkg::CPA_ST_OVF] &&
				!(wr && hit_stat && pwdata[cpa_pkg::CPA_ST_OVF]));
			// Ready after all conversions and averaging  see (RULE_11)
			if (ready_evt) begin
				conversion_ready_flag <= 1'b1;
			end else if ((ctrl_wr && new_mode != cpa_pkg::CPA_MODE_OFF) ||
					stat_clr_rd) begin
				conversion_ready_flag <= 1'b0;
			end
			// Triggered mode falls back to idle after one whole sequence
			if (seq_end && mode == cpa_pkg::CPA_MODE_TRIG && !ctrl_wr) begin
				ctrl_reg[cpa_pkg::CPA_MODE_MSB:cpa_pkg::CPA_MODE_LSB]
					<= cpa_pkg::CPA_MODE_OFF;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read mux and bus answer
	// ----------------------------------------------------------------
	// Read data is captured in the setup cycle and stands through the
	// access cycle, so the answer needs no wait state
	wire logic [31:0] rd_mux =
		hit_ctrl ? ctrl_reg :
		hit_cal ? {16'h0000, cal_reg} :
		hit_cur ? out_reg.current :
		hit_pwr ? out_reg.power :
		hit_stat ? {29'h0000_0000, conversion_ready_flag, stat_reg} :
		hit_mask ? {30'h0000_0000, mask_reg} :
		hit_smp ? {temp_reg, bus_reg} : cpa_pkg::CPA_ZERO;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prdata <= cpa_pkg::CPA_ZERO;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end
	assign pready = 1'b1;
	assign pslverr = acc && !mapped ? cpa_pkg::CPA_ERR : 1'b0;
	// Level interrupt: high while any unmasked event stays pending
	assign irq = |(stat_reg & mask_reg);
endmodule : cpa_core

// file: verif/cpa_core_assertions.sv
// Port checker for the current and power core
// Assumes it is bound onto every cpa_core instance
`timescale 1ns/1ps
module cpa_core_assertions #(
	parameter int SMP_W = 16,
	parameter int ACC_W = 48
) (
	// Clock, reset and APB
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Converter and flags
	input wire cpa_pkg::cpa_chan_t conv_chan,
	input wire logic conv_start,
	input wire cpa_pkg::cpa_sample_t conv_sample,
	input wire logic irq,
	input wire logic conversion_ready_flag
);
	// Access phase decode
	wire acc = psel && penable;
	wire ctrl_wr = acc && pwrite && paddr == cpa_pkg::CPA_CTRL_OFF;
	wire mask_wr = acc && pwrite && paddr == cpa_pkg::CPA_MASK_OFF;
	wire bad = acc && paddr > cpa_pkg::CPA_SMP_OFF;
	logic pend_reg; // Conversion outstanding
	cpa_pkg::cpa_chan_t last_reg; // Input last started
	logic [1:0] mode_reg; // Mode last written
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// Track outstanding conversion, last input and mode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pend_reg <= 1'b0;
			last_reg <= cpa_pkg::CPA_CH_BUS;
			mode_reg <= 2'b00;
		end else begin
			pend_reg <= conv_start || (pend_reg && !conv_sample.valid);
			if (conv_start) begin
				last_reg <= conv_chan;
			end
			if (ctrl_wr) begin
				mode_reg <= pwdata[1:0];
			end
		end
	end
	property p_gap;
		conv_start |=> !conv_start [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("Starts too close");
	property p_order;
		conv_start && conv_chan == cpa_pkg::CPA_CH_BUS |-> last_reg == 2'b00;
	endproperty
	a_order: assert property (p_order) else $error("Bus before shunt");
	property p_ready;
		$rose(conversion_ready_flag) |-> !pend_reg && last_reg != 2'b00;
	endproperty
	a_ready: assert property (p_ready) else $error("Ready too early");
	property p_clear;
		ctrl_wr && pwdata[1:0] != 2'b00 |=> !conversion_ready_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("Ready kept");
	property p_trig;
		mode_reg == 2'b01 && conversion_ready_flag |-> !conv_start;
	endproperty
	a_trig: assert property (p_trig) else $error("Trig did not stop");
	property p_noirq;
		mask_wr && pwdata == 32'h0000_0000 |=> !irq;
	endproperty
	a_noirq: assert property (p_noirq) else $error("Masked irq high");
	property p_err;
		bad |-> pslverr && pready;
	endproperty
	a_err: assert property (p_err) else $error("No slave error");
	property p_errdata;
		bad && !pwrite |-> prdata == 32'h0000_0000;
	endproperty
	a_errdata: assert property (p_errdata) else $error("Bad read data");
endmodule : cpa_core_assertions
bind cpa_core cpa_core_assertions #(.SMP_W(SMP_W), .ACC_W(ACC_W)) u_chk (
	.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .conv_chan(conv_chan),
	.conv_start(conv_start), .conv_sample(conv_sample), .irq(irq),
	.conversion_ready_flag(conversion_ready_flag)
);

// file: verif/cpa_conv_model.sv
// Behavioural shared converter, answers each start after a set latency
// Assumes one start at a time from the core
`timescale 1ns/1ps
module cpa_conv_model (
	// Clock, reset and latency
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] lat,
	// Converter side
	input wire cpa_pkg::cpa_chan_t conv_chan,
	input wire logic conv_start,
	output cpa_pkg::cpa_sample_t conv_sample
);
	logic busy_reg; // Conversion running
	logic [7:0] cnt_reg; // Cycles left
	cpa_pkg::cpa_chan_t chan_reg; // Input in conversion
	logic [15:0] bus_reg; // Next bus value, alternates
	// One conversion at a time; idle data toggles every cycle
	always_ff @(posedge core_clk) begin
		conv_sample.valid <= 1'b0;
		conv_sample.data <= ~conv_sample.data;
		if (rst) begin
			busy_reg <= 1'b0;
			bus_reg <= 16'h0010;
			conv_sample <= '0;
		end else if (conv_start && !busy_reg) begin
			busy_reg <= 1'b1;
			cnt_reg <= lat;
			chan_reg <= conv_chan;
		end else if (busy_reg && cnt_reg == 8'h00) begin
			busy_reg <= 1'b0;
			conv_sample.valid <= 1'b1;
			conv_sample.chan <= chan_reg;
			conv_sample.data <= chan_reg == 2'b00 ? 16'h0100 : bus_reg;
			if (chan_reg == cpa_pkg::CPA_CH_BUS) begin
				bus_reg <= bus_reg ^ 16'h0020;
			end
		end else if (busy_reg) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end
endmodule : cpa_conv_model

// file: verif/tb_cpa_core.sv
// Self-checking bench for the current and power core
// Assumes the converter model and the bound port checker
`timescale 1ns/1ps
module tb_cpa_core;
	// Ordinary case: setup beside expected results
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] cal;
		logic [7:0] lat;
		logic [31:0] cur;
		logic [31:0] pwr;
		logic pchk;
	} cpa_row_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [7:0] lat = 8'h02;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, q;
	logic pready, pslverr, irq, conversion_ready_flag, conv_start, e;
	cpa_pkg::cpa_chan_t conv_chan;
	cpa_pkg::cpa_sample_t conv_sample;
	int err_count = 0;
	int checks_done = 0;
	// Shunt 0x100, bus 0x10 and 0x30 in turn from the model
	cpa_row_t rows [4] = '{
		'{32'h0000_0001, 16'h0000, 8'h02, 32'h0, 32'h0, 1'b1},
		'{32'h0000_0001, 16'h0200, 8'hC8, 32'h0002_0000, 32'h60, 1'b1},
		'{32'h0000_0001, 16'h0200, 8'h02, 32'h0002_0000, 32'h20, 1'b1},
		'{32'h0000_0011, 16'h0200, 8'h02, 32'h0002_0000, 32'h40, 1'b1}};
	always #5 core_clk = ~core_clk;
	cpa_core dut (.core_clk(core_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conv_chan(conv_chan), .conv_start(conv_start),
		.conv_sample(conv_sample), .irq(irq),
		.conversion_ready_flag(conversion_ready_flag));
	cpa_conv_model u_conv (.core_clk(core_clk), .rst(rst), .lat(lat),
		.conv_chan(conv_chan), .conv_start(conv_start),
		.conv_sample(conv_sample));
	// One APB transfer, read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic chk(input string n, input logic [31:0] x, logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			$display("[ERR] %s expected %h seen %h", n, x, g);
			err_count++;
		end
	endtask : chk
	task automatic wait_ready;
		for (int n = 0; n < 60000 && conversion_ready_flag !== 1'b1; n++) begin
			@(posedge core_clk);
		end
		// A wait that runs out counts as a mismatch
		chk("wait_flag", 32'h1, {31'h0, conversion_ready_flag});
	endtask : wait_ready
	task automatic conclude;
		if (err_count == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude
	// Watchdog over the whole run
	initial begin
		#1_100_000;
		err_count++;
		conclude();
	end
	// Reset, table of cases, then a restart in mid-average
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, cpa_pkg::CPA_CTRL_OFF, 32'h0);
		chk("ctrl_reset", 32'h0, q);
		apb(1'b0, 8'h40, 32'h0);
		chk("bad_data", 32'h0, q);
		chk("bad_err", {31'h0, cpa_pkg::CPA_ERR}, {31'h0, e});
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, cpa_pkg::CPA_MASK_OFF, {31'h0, i != 0});
			lat <= rows[i].lat;
			apb(1'b1, cpa_pkg::CPA_CAL_OFF, {16'h0, rows[i].cal});
			apb(1'b1, cpa_pkg::CPA_CTRL_OFF, rows[i].ctrl);
			#1 chk("flag_start", 32'h0, {31'h0, conversion_ready_flag});
			wait_ready();
			apb(1'b0, cpa_pkg::CPA_CUR_OFF, 32'h0);
			chk("current", rows[i].cur, q);
			apb(1'b0, cpa_pkg::CPA_PWR_OFF, 32'h0);
			if (rows[i].pchk) chk("power", rows[i].pwr, q);
			chk("irq_set", {31'h0, i != 0}, {31'h0, irq});
			apb(1'b0, cpa_pkg::CPA_STAT_OFF, 32'h0);
			chk("ready_evt", 32'h1, q & 32'h0000_0001);
			#1 chk("flag_clear", 32'h0, {31'h0, conversion_ready_flag});
			apb(1'b1, cpa_pkg::CPA_STAT_OFF, 32'h0000_0001);
			#1 chk("irq_clear", 32'h0, {31'h0, irq});
		end
		// Interrupted average, then a continuous restart from empty sums
		apb(1'b1, cpa_pkg::CPA_CTRL_OFF, 32'h0000_0011);
		repeat (11000) @(posedge core_clk);
		apb(1'b1, cpa_pkg::CPA_CTRL_OFF, 32'h0000_0002);
		wait_ready();
		apb(1'b0, cpa_pkg::CPA_CUR_OFF, 32'h0);
		chk("cur_restart", 32'h0002_0000, q);
		apb(1'b0, cpa_pkg::CPA_PWR_OFF, 32'h0);
		chk("pwr_restart", 32'h0000_0020, q);
		apb(1'b0, cpa_pkg::CPA_STAT_OFF, 32'h0);
		#1 chk("flag_again", 32'h0, {31'h0, conversion_ready_flag});
		// Continuous mode runs a second pass on its own
		wait_ready();
		apb(1'b0, cpa_pkg::CPA_PWR_OFF, 32'h0);
		chk("pwr_loop", 32'h0000_0060, q);
		// Reset in mid-run empties the published results
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, cpa_pkg::CPA_CUR_OFF, 32'h0);
		chk("cur_reset", 32'h0, q);
		conclude();
	end
endmodule : tb_cpa_core
